// *** rtl/link_pdu_pkg.sv ***
package link_pdu_pkg;

	// Register bus geometry
	localparam int REG_AW = 8;
	localparam int REG_DW = 32;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_SEQ = 8'h0C;
	localparam logic [7:0] OFS_HOLD = 8'h10;
	localparam logic [7:0] OFS_BUF = 8'h14;

	// Control register fields
	localparam int CTRL_BUSY_BIT = 0;
	localparam int CTRL_ADDR_LSB = 8;

	// Command register fields (write only, reads as zero)
	localparam int CMD_I_BIT = 0;
	localparam int CMD_S_BIT = 1;
	localparam int CMD_GRP_BIT = 2;
	localparam int CMD_SK_LSB = 3;
	localparam int CMD_PF_BIT = 5;
	localparam int CMD_DST_LSB = 8;
	localparam int CMD_LEN_LSB = 16;

	// Status register fields; bits 2..4 are sticky, write one to clear
	localparam int ST_ACTIVE_BIT = 0;
	localparam int ST_RESP_BIT = 1;
	localparam int ST_TRUNC_BIT = 2;
	localparam int ST_SEQERR_BIT = 3;
	localparam int ST_REFUSED_BIT = 4;

	// Sequence register fields
	localparam int SEQ_VS_LSB = 0;
	localparam int SEQ_VR_LSB = 8;
	localparam int SEQ_ACK_LSB = 16;

	// Buffer write register fields
	localparam int BUF_DATA_LSB = 0;
	localparam int BUF_IDX_LSB = 16;

	// Response hold delay: reset value in ns, rounded up to clock cycles
	localparam int CLK_PERIOD_NS = 50;
	localparam int HOLD_W = 16;
	localparam int HOLD_DEFAULT_NS = 1000;
	localparam int HOLD_DEFAULT_CYC = (HOLD_DEFAULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [HOLD_W-1:0] HOLD_RESET = HOLD_W'(HOLD_DEFAULT_CYC);

	// Kind of PDU on the receive and transmit ports
	typedef enum logic [2:0] {
		PDU_OTHER = 3'h0,
		PDU_TEST_CMD = 3'h1,
		PDU_TEST_RSP = 3'h2,
		PDU_UI_CMD = 3'h3,
		PDU_URNR_RSP = 3'h4,
		PDU_I = 3'h5,
		PDU_S = 3'h6
	} pdu_kind_t;

	// Kind of destination address
	typedef enum logic [1:0] {
		DST_INDIV = 2'h0,
		DST_GROUP = 2'h1,
		DST_GLOBAL = 2'h2,
		DST_SPECIAL = 2'h3
	} dst_kind_t;

	// Supervisory function
	typedef enum logic [1:0] {
		SUP_READY = 2'h0,
		SUP_REJECT = 2'h1,
		SUP_NOT_READY = 2'h2,
		SUP_SEL_REJECT = 2'h3
	} sup_kind_t;

	// Transmit sequencer, Gray coded from idle through hold, header and data to done
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_HOLD = 3'h1,
		ST_HDR = 3'h3,
		ST_DATA = 3'h2,
		ST_DONE = 3'h6
	} tx_state_t;

endpackage : link_pdu_pkg

// *** rtl/link_pdu_responder.sv ***
`timescale 1ns/1ps
`default_nettype none

// Operation
// - A TEST command that is answered gets its TEST response sent first, once the hold delay has run out; the code first completes any software PDU already started.
// - A TEST command with poll 0 to any address kind is answered with a TEST response with final bit 0.
// - The TEST response to a poll 0 command echoes the received information field unchanged;
//   the code sends it empty if the field overflows the buffer or the buffer is in use.
// - A TEST response carries the station's own individual source address and an individual destination.
// - A UI command with poll 1 arriving while the station is busy is answered with a URNR response.
// - A URNR response is the first PDU sent after the UI command, and only after the hold delay; a software PDU already started is completed before it.
// - A URNR response has final bit 1 and goes to the source address of the UI command.
// - I PDUs always carry an information field and are numbered in sequence on a connection.
// - Group or global I PDUs are sent with both sequence numbers zero and are ignored and not acknowledged on receipt.
// - An I PDU carries its own send number and the next expected receive number, which acknowledges all below it.
// - S PDUs perform numbered supervisory work: acknowledgement, suspension and recovery.
// - S PDUs carry no information field and change neither the send nor the receive state variable.
// - An individually addressed TEST command with poll 1 gets a TEST response with final 1 and no information.
// - Every S PDU carries the next expected receive number, acknowledging all below it unless it is a selective reject without poll;
//   an S PDU sent with the group bit set carries zero instead.
module link_pdu_responder #(
	parameter int ADDR_W = 8,
	parameter int SEQ_W = 7,
	parameter int BUF_DEPTH = 64
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [link_pdu_pkg::REG_AW-1:0] reg_addr,
	input wire logic [link_pdu_pkg::REG_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [link_pdu_pkg::REG_DW-1:0] reg_rdata,
	input wire logic rx_hdr_valid,
	input wire link_pdu_pkg::pdu_kind_t rx_kind,
	input wire logic rx_pf,
	input wire link_pdu_pkg::dst_kind_t rx_dst_kind,
	input wire logic [ADDR_W-1:0] rx_src,
	input wire logic [SEQ_W-1:0] rx_ns,
	input wire logic [SEQ_W-1:0] rx_nr,
	input wire link_pdu_pkg::sup_kind_t rx_sup,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_end,
	output logic tx_hdr_valid,
	output link_pdu_pkg::pdu_kind_t tx_kind,
	output logic tx_pf,
	output link_pdu_pkg::dst_kind_t tx_dst_kind,
	output logic [ADDR_W-1:0] tx_src,
	output logic [ADDR_W-1:0] tx_dst,
	output logic [SEQ_W-1:0] tx_ns,
	output logic [SEQ_W-1:0] tx_nr,
	output link_pdu_pkg::sup_kind_t tx_sup,
	output logic tx_byte_valid,
	output logic [7:0] tx_byte,
	output logic tx_end,
	input wire logic tx_ready
);
	localparam int BIDX_W = $clog2(BUF_DEPTH);
	localparam int LEN_W = $clog2(BUF_DEPTH + 1);
	localparam logic [LEN_W-1:0] LEN_FULL = LEN_W'(BUF_DEPTH);
	// Address decode shared by reads and writes
	function automatic logic hit(input logic [link_pdu_pkg::REG_AW-1:0] a, input logic [link_pdu_pkg::REG_AW-1:0] o);
		return a == o;
	endfunction : hit
	// Software state
	logic busy, st_trunc, st_seq_err, st_refused;
	logic [ADDR_W-1:0] my_addr;
	logic [link_pdu_pkg::HOLD_W-1:0] hold_cyc;
	// Connection sequence state
	logic [SEQ_W-1:0] vs, vr, peer_ack;
	// Frame being received; header copies need no reset since in_frame gates every use
	logic in_frame, cur_pf, cap_en, rx_over;
	link_pdu_pkg::pdu_kind_t cur_kind;
	link_pdu_pkg::dst_kind_t cur_dst;
	logic [ADDR_W-1:0] cur_src;
	logic [SEQ_W-1:0] cur_ns, cur_nr;
	link_pdu_pkg::sup_kind_t cur_sup;
	logic [LEN_W-1:0] rx_cnt;
	// Pending answer to a command
	logic resp_pend, resp_pf;
	link_pdu_pkg::pdu_kind_t resp_kind;
	logic [ADDR_W-1:0] resp_dst;
	logic [LEN_W-1:0] resp_len;
	// Pending software request
	logic sw_pend, sw_is_i, sw_grp, sw_pf;
	link_pdu_pkg::sup_kind_t sw_sup;
	logic [ADDR_W-1:0] sw_dst;
	logic [LEN_W-1:0] sw_len;
	// Transmit sequencer
	link_pdu_pkg::tx_state_t state, next_state;
	logic [link_pdu_pkg::HOLD_W-1:0] hold_cnt;
	logic [LEN_W-1:0] tx_idx, next_idx, send_len;
	logic sending_resp;
	logic [7:0] buf_mem [BUF_DEPTH];
	// Register strobes
	wire logic wr_ctrl = reg_wr && hit(reg_addr, link_pdu_pkg::OFS_CTRL);
	wire logic wr_cmd = reg_wr && hit(reg_addr, link_pdu_pkg::OFS_CMD);
	wire logic wr_status = reg_wr && hit(reg_addr, link_pdu_pkg::OFS_STATUS);
	wire logic wr_hold = reg_wr && hit(reg_addr, link_pdu_pkg::OFS_HOLD);
	wire logic wr_buf = reg_wr && hit(reg_addr, link_pdu_pkg::OFS_BUF);
	// Command fields
	wire logic cmd_i = reg_wdata[link_pdu_pkg::CMD_I_BIT];
	wire logic cmd_s = reg_wdata[link_pdu_pkg::CMD_S_BIT];
	wire logic [LEN_W-1:0] cmd_len = reg_wdata[link_pdu_pkg::CMD_LEN_LSB +: LEN_W];
	wire logic cmd_bad_len = cmd_i && (cmd_len == '0 || cmd_len > LEN_FULL);
	wire logic cmd_take = wr_cmd && (cmd_i || cmd_s) && !sw_pend && !cmd_bad_len;
	wire logic cmd_refuse = wr_cmd && (cmd_i || cmd_s) && !cmd_take;
	// The buffer belongs to software only while nothing uses it
	wire logic buf_free = state == link_pdu_pkg::ST_IDLE && !resp_pend && !sw_pend;
	wire logic sw_we = wr_buf && buf_free && !cap_en;
	wire logic buf_refuse = wr_buf && !sw_we;
	// Echo capture of a poll 0 TEST command
	wire logic is_echo_hdr = rx_kind == link_pdu_pkg::PDU_TEST_CMD && !rx_pf;
	wire logic rx_we = in_frame && cap_en && rx_byte_valid && rx_cnt != LEN_FULL;
	wire logic rx_lost = in_frame && rx_byte_valid && cur_kind == link_pdu_pkg::PDU_TEST_CMD && !cur_pf && !rx_we;
	wire logic buf_we = rx_we || sw_we;
	wire logic [BIDX_W-1:0] buf_waddr = rx_we ? rx_cnt[BIDX_W-1:0]
		: reg_wdata[link_pdu_pkg::BUF_IDX_LSB +: BIDX_W];
	wire logic [7:0] buf_wdata = rx_we ? rx_byte : reg_wdata[link_pdu_pkg::BUF_DATA_LSB +: 8];
	// Decisions at the end of a received frame
	wire logic frame_done = in_frame && rx_end;
	wire logic cur_indiv = cur_dst == link_pdu_pkg::DST_INDIV;
	wire logic ans_test = cur_kind == link_pdu_pkg::PDU_TEST_CMD && (!cur_pf || cur_indiv);
	wire logic ans_urnr = cur_kind == link_pdu_pkg::PDU_UI_CMD && cur_pf && busy;
	wire logic new_resp = frame_done && !resp_pend && (ans_test || ans_urnr);
	wire logic resp_lost = frame_done && resp_pend && (ans_test || ans_urnr);
	wire logic i_indiv = frame_done && cur_kind == link_pdu_pkg::PDU_I && cur_indiv;
	wire logic i_in_seq = i_indiv && cur_ns == vr;
	wire logic s_ack = frame_done && cur_kind == link_pdu_pkg::PDU_S && cur_indiv
		&& (cur_sup != link_pdu_pkg::SUP_SEL_REJECT || cur_pf);
	// Header of the next PDU: an answer when coming from the hold state
	wire logic load_resp = state == link_pdu_pkg::ST_HOLD;
	wire logic hdr_grp = !load_resp && sw_grp;
	wire logic hdr_numbered = !load_resp && sw_is_i && !hdr_grp;
	wire link_pdu_pkg::pdu_kind_t hdr_kind = load_resp ? resp_kind
		: (sw_is_i ? link_pdu_pkg::PDU_I : link_pdu_pkg::PDU_S);
	wire link_pdu_pkg::dst_kind_t hdr_dkind = hdr_grp ? link_pdu_pkg::DST_GROUP : link_pdu_pkg::DST_INDIV;
	wire logic [SEQ_W-1:0] hdr_ns = hdr_numbered ? vs : '0;
	wire logic [SEQ_W-1:0] hdr_nr = (load_resp || hdr_grp) ? '0 : vr;
	wire logic [LEN_W-1:0] hdr_len = load_resp ? resp_len : (sw_is_i ? sw_len : '0);
	wire logic enter_hdr = state != link_pdu_pkg::ST_HDR && next_state == link_pdu_pkg::ST_HDR;
	wire logic hdr_sent = state == link_pdu_pkg::ST_HDR && tx_ready;
	wire logic pdu_done = state == link_pdu_pkg::ST_DONE && tx_ready;
	// Control and hold registers
	always_ff @(posedge clk) begin
		if (rst) begin
			busy <= 1'h0;
			my_addr <= '0;
			hold_cyc <= link_pdu_pkg::HOLD_RESET;
		end else begin
			if (wr_ctrl) begin
				busy <= reg_wdata[link_pdu_pkg::CTRL_BUSY_BIT];
				my_addr <= reg_wdata[link_pdu_pkg::CTRL_ADDR_LSB +: ADDR_W];
			end
			if (wr_hold)
				hold_cyc <= reg_wdata[0 +: link_pdu_pkg::HOLD_W];
		end
	end
	// Sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			st_trunc <= 1'h0;
			st_seq_err <= 1'h0;
			st_refused <= 1'h0;
		end else begin
			st_trunc <= rx_lost || (st_trunc && !(wr_status && reg_wdata[link_pdu_pkg::ST_TRUNC_BIT]));
			st_seq_err <= (i_indiv && !i_in_seq) || (st_seq_err && !(wr_status && reg_wdata[link_pdu_pkg::ST_SEQERR_BIT]));
			st_refused <= cmd_refuse || buf_refuse || resp_lost
				|| (st_refused && !(wr_status && reg_wdata[link_pdu_pkg::ST_REFUSED_BIT]));
		end
	end
	// Receive frame tracking; header fields held until the frame ends
	always_ff @(posedge clk) begin
		if (rst) begin
			in_frame <= 1'h0;
			cap_en <= 1'h0;
			rx_cnt <= '0;
			rx_over <= 1'h0;
		end else if (rx_hdr_valid) begin
			in_frame <= 1'h1;
			cur_kind <= rx_kind;
			cur_pf <= rx_pf;
			cur_dst <= rx_dst_kind;
			cur_src <= rx_src;
			cur_ns <= rx_ns;
			cur_nr <= rx_nr;
			cur_sup <= rx_sup;
			cap_en <= is_echo_hdr && buf_free; // Echo only into an idle buffer
			rx_cnt <= '0;
			rx_over <= is_echo_hdr && !buf_free;
		end else begin
			if (rx_we)
				rx_cnt <= rx_cnt + LEN_W'(1);
			if (rx_lost)
				rx_over <= 1'h1;
			if (rx_end) begin
				in_frame <= 1'h0;
				cap_en <= 1'h0;
			end
		end
	end
	// Receive state variable and acknowledgement from the peer
	always_ff @(posedge clk) begin
		if (rst) begin
			vr <= '0;
			peer_ack <= '0;
		end else begin
			if (i_in_seq)
				vr <= vr + SEQ_W'(1);
			if (i_indiv || s_ack)
				peer_ack <= cur_nr;
		end
	end
	// Pending answer; fields are only read while the answer is pending
	always_ff @(posedge clk) begin
		if (rst) begin
			resp_pend <= 1'h0;
		end else if (new_resp) begin
			resp_pend <= 1'h1;
			resp_kind <= ans_test ? link_pdu_pkg::PDU_TEST_RSP : link_pdu_pkg::PDU_URNR_RSP;
			resp_pf <= ans_test ? cur_pf : 1'h1;
			resp_dst <= cur_src;
			resp_len <= (ans_test && !cur_pf && !rx_over) ? rx_cnt : '0;
		end else if (pdu_done && sending_resp) begin
			resp_pend <= 1'h0;
		end
	end
	// Software request latch; sw_sup is reset as answers copy it to the header
	always_ff @(posedge clk) begin
		if (rst) begin
			sw_pend <= 1'h0;
			sw_sup <= link_pdu_pkg::SUP_READY;
		end else if (cmd_take) begin
			sw_pend <= 1'h1;
			sw_is_i <= cmd_i;
			sw_grp <= reg_wdata[link_pdu_pkg::CMD_GRP_BIT];
			sw_sup <= link_pdu_pkg::sup_kind_t'(reg_wdata[link_pdu_pkg::CMD_SK_LSB +: 2]);
			sw_pf <= reg_wdata[link_pdu_pkg::CMD_PF_BIT];
			sw_dst <= reg_wdata[link_pdu_pkg::CMD_DST_LSB +: ADDR_W];
			sw_len <= cmd_len;
		end else if (pdu_done && !sending_resp) begin
			sw_pend <= 1'h0;
		end
	end
	// Shared buffer: echo field or outgoing information field
	always_ff @(posedge clk) begin
		if (buf_we) begin
			buf_mem[buf_waddr] <= buf_wdata;
		end
	end
	// Next state; a pending answer always wins the idle slot
	always_comb begin
		next_state = state;
		next_idx = tx_idx;
		case (state)
			link_pdu_pkg::ST_IDLE: begin
				if (resp_pend) begin
					next_state = link_pdu_pkg::ST_HOLD;
				end else if (sw_pend) begin
					next_state = link_pdu_pkg::ST_HDR;
				end
			end
			link_pdu_pkg::ST_HOLD: begin
				if (hold_cnt == '0) begin
					next_state = link_pdu_pkg::ST_HDR;
				end
			end
			link_pdu_pkg::ST_HDR: begin
				if (tx_ready) begin
					next_idx = '0;
					next_state = (send_len != '0) ? link_pdu_pkg::ST_DATA : link_pdu_pkg::ST_DONE;
				end
			end
			link_pdu_pkg::ST_DATA: begin
				if (tx_ready) begin
					if (tx_idx == send_len - LEN_W'(1)) begin
						next_state = link_pdu_pkg::ST_DONE;
					end else begin
						next_idx = tx_idx + LEN_W'(1);
					end
				end
			end
			link_pdu_pkg::ST_DONE: begin
				if (tx_ready) begin
					next_state = link_pdu_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = link_pdu_pkg::ST_IDLE;
			end
		endcase
	end
	// Sequencer, hold counter and send state variable
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= link_pdu_pkg::ST_IDLE;
			hold_cnt <= '0;
			tx_idx <= '0;
			vs <= '0;
		end else begin
			state <= next_state;
			tx_idx <= next_idx;
			if (state == link_pdu_pkg::ST_IDLE)
				hold_cnt <= hold_cyc;
			else if (hold_cnt != '0)
				hold_cnt <= hold_cnt - link_pdu_pkg::HOLD_W'(1);
			if (hdr_sent && tx_kind == link_pdu_pkg::PDU_I && tx_dst_kind == link_pdu_pkg::DST_INDIV)
				vs <= vs + SEQ_W'(1);
		end
	end
	// Header outputs, loaded once as the header beat begins
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_kind <= link_pdu_pkg::PDU_OTHER;
			tx_pf <= 1'h0;
			tx_dst_kind <= link_pdu_pkg::DST_INDIV;
			tx_src <= '0;
			tx_dst <= '0;
			tx_ns <= '0;
			tx_nr <= '0;
			tx_sup <= link_pdu_pkg::SUP_READY;
		end else if (enter_hdr) begin
			tx_kind <= hdr_kind;
			tx_pf <= load_resp ? resp_pf : sw_pf;
			tx_dst_kind <= hdr_dkind;
			tx_src <= my_addr;
			tx_dst <= load_resp ? resp_dst : sw_dst;
			tx_ns <= hdr_ns;
			tx_nr <= hdr_nr;
			tx_sup <= sw_sup;
			send_len <= hdr_len;
			sending_resp <= load_resp;
		end
	end
	// Beat outputs follow the next state so they come from flip-flops
	always_ff @(posedge clk) begin
		tx_hdr_valid <= !rst && next_state == link_pdu_pkg::ST_HDR;
		tx_byte_valid <= !rst && next_state == link_pdu_pkg::ST_DATA;
		tx_byte <= rst ? 8'h00 : buf_mem[next_idx[BIDX_W-1:0]];
		tx_end <= !rst && next_state == link_pdu_pkg::ST_DONE;
	end
	// Read mux; unmapped and write-only offsets read zero
	wire logic [link_pdu_pkg::REG_DW-1:0] rd_ctrl = (link_pdu_pkg::REG_DW'(busy) << link_pdu_pkg::CTRL_BUSY_BIT)
		| (link_pdu_pkg::REG_DW'(my_addr) << link_pdu_pkg::CTRL_ADDR_LSB);
	wire logic [link_pdu_pkg::REG_DW-1:0] rd_status =
		(link_pdu_pkg::REG_DW'(state != link_pdu_pkg::ST_IDLE) << link_pdu_pkg::ST_ACTIVE_BIT)
		| (link_pdu_pkg::REG_DW'(resp_pend) << link_pdu_pkg::ST_RESP_BIT)
		| (link_pdu_pkg::REG_DW'(st_trunc) << link_pdu_pkg::ST_TRUNC_BIT)
		| (link_pdu_pkg::REG_DW'(st_seq_err) << link_pdu_pkg::ST_SEQERR_BIT)
		| (link_pdu_pkg::REG_DW'(st_refused) << link_pdu_pkg::ST_REFUSED_BIT);
	wire logic [link_pdu_pkg::REG_DW-1:0] rd_seq = (link_pdu_pkg::REG_DW'(vs) << link_pdu_pkg::SEQ_VS_LSB)
		| (link_pdu_pkg::REG_DW'(vr) << link_pdu_pkg::SEQ_VR_LSB)
		| (link_pdu_pkg::REG_DW'(peer_ack) << link_pdu_pkg::SEQ_ACK_LSB);
	wire logic [link_pdu_pkg::REG_DW-1:0] rd_data =
		hit(reg_addr, link_pdu_pkg::OFS_CTRL) ? rd_ctrl
		: hit(reg_addr, link_pdu_pkg::OFS_STATUS) ? rd_status
		: hit(reg_addr, link_pdu_pkg::OFS_SEQ) ? rd_seq
		: hit(reg_addr, link_pdu_pkg::OFS_HOLD) ? link_pdu_pkg::REG_DW'(hold_cyc)
		: '0;
	// Read data stands for exactly the cycle after the strobe
	always_ff @(posedge clk) begin
		reg_rdata <= (reg_rd && !rst) ? rd_data : '0;
	end

endmodule : link_pdu_responder

`default_nettype wire

// *** dv/link_pdu_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level watch on the responder's answers, transmit beats and read path
module link_pdu_chk #(
	parameter int SEQ_W = 7
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_rd,
	input wire logic [link_pdu_pkg::REG_DW-1:0] reg_rdata,
	input wire link_pdu_pkg::pdu_kind_t rx_kind,
	input wire logic rx_pf,
	input wire logic rx_end,
	input wire logic tx_hdr_valid,
	input wire link_pdu_pkg::pdu_kind_t tx_kind,
	input wire logic tx_pf,
	input wire link_pdu_pkg::dst_kind_t tx_dst_kind,
	input wire logic [SEQ_W-1:0] tx_ns,
	input wire logic [SEQ_W-1:0] tx_nr,
	input wire logic tx_byte_valid,
	input wire logic tx_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// A TEST command with poll 0 has just been taken
	sequence s_test_in;
		rx_end && rx_kind == link_pdu_pkg::PDU_TEST_CMD && !rx_pf;
	endsequence
	// The answer header that must come first
	sequence s_test_rsp;
		tx_hdr_valid && tx_kind == link_pdu_pkg::PDU_TEST_RSP;
	endsequence

	property p_rdata_quiet;
		!$past(reg_rd) |-> reg_rdata == '0;
	endproperty
	property p_hdr_hold;
		tx_hdr_valid && !tx_ready |=> tx_hdr_valid && $stable(tx_kind) && $stable(tx_pf) && $stable(tx_ns);
	endproperty
	property p_test_hold;
		s_test_in |=> !tx_hdr_valid [*2];
	endproperty
	property p_test_first;
		s_test_in |=> !tx_hdr_valid until s_test_rsp;
	endproperty
	property p_test_soon;
		s_test_in |-> ##[3:40] s_test_rsp;
	endproperty
	property p_rsp_indiv;
		s_test_rsp |-> tx_dst_kind == link_pdu_pkg::DST_INDIV;
	endproperty
	property p_urnr_fields;
		tx_hdr_valid && tx_kind == link_pdu_pkg::PDU_URNR_RSP |-> tx_pf && tx_dst_kind == link_pdu_pkg::DST_INDIV;
	endproperty
	property p_i_info;
		tx_hdr_valid && tx_ready && tx_kind == link_pdu_pkg::PDU_I |=> tx_byte_valid;
	endproperty
	property p_grp_i_zero;
		tx_hdr_valid && tx_kind == link_pdu_pkg::PDU_I && tx_dst_kind != link_pdu_pkg::DST_INDIV |-> tx_ns == '0 && tx_nr == '0;
	endproperty
	property p_s_no_info;
		tx_kind == link_pdu_pkg::PDU_S |-> !tx_byte_valid;
	endproperty

	a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside read slot");
	a_hdr_hold: assert property (p_hdr_hold) else $error("header dropped or changed while stalled");
	a_test_hold: assert property (p_test_hold) else $error("answer sent before hold");
	a_test_first: assert property (p_test_first) else $error("other pdu before test answer");
	a_test_soon: assert property (p_test_soon) else $error("test answer late");
	a_rsp_indiv: assert property (p_rsp_indiv) else $error("test answer not individual");
	a_urnr_fields: assert property (p_urnr_fields) else $error("busy answer fields wrong");
	a_i_info: assert property (p_i_info) else $error("numbered pdu without data");
	a_grp_i_zero: assert property (p_grp_i_zero) else $error("group pdu sequence not zero");
	a_s_no_info: assert property (p_s_no_info) else $error("supervisory pdu with data");
endmodule : link_pdu_chk

bind link_pdu_responder link_pdu_chk #(.SEQ_W(SEQ_W)) i_link_pdu_chk (.clk(clk), .rst(rst), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .rx_kind(rx_kind), .rx_pf(rx_pf), .rx_end(rx_end), .tx_hdr_valid(tx_hdr_valid),
	.tx_kind(tx_kind), .tx_pf(tx_pf), .tx_dst_kind(tx_dst_kind), .tx_ns(tx_ns), .tx_nr(tx_nr),
	.tx_byte_valid(tx_byte_valid), .tx_ready(tx_ready));
`default_nettype wire

// *** dv/peer_station.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behavioural peer: sends frames when asked, accepts answers, stalls when told
module peer_station (
	input wire logic clk,
	input wire logic stall,
	output logic rx_hdr_valid,
	output link_pdu_pkg::pdu_kind_t rx_kind,
	output logic rx_pf,
	output link_pdu_pkg::dst_kind_t rx_dst_kind,
	output logic [7:0] rx_src,
	output logic [6:0] rx_ns,
	output logic [6:0] rx_nr,
	output link_pdu_pkg::sup_kind_t rx_sup,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic rx_end,
	input wire logic tx_hdr_valid,
	input wire link_pdu_pkg::pdu_kind_t tx_kind,
	input wire logic tx_pf,
	input wire logic [7:0] tx_src,
	input wire logic [7:0] tx_dst,
	input wire logic [6:0] tx_ns,
	input wire logic [6:0] tx_nr,
	input wire logic tx_byte_valid,
	input wire logic [7:0] tx_byte,
	input wire logic tx_end,
	output logic tx_ready,
	output logic [33:0] got_hdr,
	output logic [31:0] got_data,
	output logic [7:0] got_bytes,
	output logic [7:0] got_frames
);
	initial begin
		{rx_hdr_valid, rx_pf, rx_src, rx_ns, rx_nr, rx_byte_valid, rx_byte, rx_end} = '0;
		rx_kind = link_pdu_pkg::PDU_OTHER;
		rx_dst_kind = link_pdu_pkg::DST_INDIV;
		rx_sup = link_pdu_pkg::SUP_READY;
		{tx_ready, got_hdr, got_data, got_bytes, got_frames} = '0;
	end

	// Accept beats; in stall mode ready toggles so every beat waits once in two
	always @(posedge clk) begin
		tx_ready <= stall ? !tx_ready : 1'b1;
		if (tx_hdr_valid && tx_ready) begin
			got_hdr <= {tx_kind, tx_pf, tx_src, tx_dst, tx_ns, tx_nr};
			got_bytes <= '0;
			got_data <= '0;
		end
		if (tx_byte_valid && tx_ready) begin
			got_bytes <= got_bytes + 8'h01;
			got_data <= {got_data[23:0], tx_byte};
		end
		if (tx_end && tx_ready)
			got_frames <= got_frames + 8'h01;
	end

	// One whole frame; header fields stay put up to the end beat
	task automatic send(input link_pdu_pkg::pdu_kind_t k, input logic pf, input link_pdu_pkg::dst_kind_t dk,
		input logic [7:0] src, input logic [6:0] ns, input logic [6:0] nr, input link_pdu_pkg::sup_kind_t sup,
		input int n, input logic [31:0] data);
		@(posedge clk);
		rx_hdr_valid <= 1'b1;
		{rx_kind, rx_pf, rx_dst_kind, rx_src, rx_ns, rx_nr, rx_sup} <= {k, pf, dk, src, ns, nr, sup};
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			rx_hdr_valid <= 1'b0;
			rx_byte_valid <= 1'b1;
			rx_byte <= data[31-8*i -: 8];
		end
		@(posedge clk);
		rx_hdr_valid <= 1'b0;
		rx_byte_valid <= 1'b0;
		rx_byte <= ~rx_byte; // Released data never shows the old byte
		rx_end <= 1'b1;
		@(posedge clk);
		rx_end <= 1'b0;
		rx_src <= ~rx_src;
	endtask : send
endmodule : peer_station
`default_nettype wire

// *** dv/link_pdu_responder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// Register access, TEST and busy answers, numbered and supervisory traffic
module link_pdu_responder_tb;
	localparam logic [7:0] ME = 8'h21;
	logic clk, rst, reg_wr, reg_rd, stall, rx_hdr_valid, rx_pf, rx_byte_valid, rx_end, tx_hdr_valid, tx_pf;
	logic tx_byte_valid, tx_end, tx_ready;
	logic [7:0] reg_addr, rx_src, rx_byte, tx_src, tx_dst, tx_byte, got_bytes, got_frames, n;
	logic [31:0] reg_wdata, reg_rdata, got_data;
	logic [6:0] rx_ns, rx_nr, tx_ns, tx_nr;
	logic [33:0] got_hdr;
	link_pdu_pkg::pdu_kind_t rx_kind, tx_kind;
	link_pdu_pkg::dst_kind_t rx_dst_kind, tx_dst_kind;
	link_pdu_pkg::sup_kind_t rx_sup, tx_sup;
	int errors, samples_checked, lat;

	link_pdu_responder i_link_pdu_responder (.*);
	peer_station i_peer_station (.*);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic summarize();
		if (errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input string what, input logic [31:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, exp, reg_rdata);
	endtask : rd

	// Bounded wait for one more completed transmit frame
	task automatic wait_frame();
		for (int i = 0; i < 400 && got_frames == n; i++)
			@(posedge clk);
		if (got_frames == n) begin
			errors++;
			summarize();
		end
		n = got_frames;
	endtask : wait_frame

	// Expected header of a PDU sent from this station
	function automatic logic [33:0] hd(input link_pdu_pkg::pdu_kind_t k, input logic pf, input logic [7:0] d,
		input logic [13:0] seq);
		return {k, pf, ME, d, seq};
	endfunction : hd

	initial begin
		errors = 0;
		samples_checked = 0;
		{rst, reg_wr, reg_rd, reg_addr, reg_wdata, stall} <= {1'b1, 43'h0};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		n = 8'h00;
		rd(link_pdu_pkg::OFS_HOLD, "hold reset", 32'(link_pdu_pkg::HOLD_RESET));
		rd(link_pdu_pkg::OFS_SEQ, "seq reset", 32'h0);
		rd(link_pdu_pkg::OFS_CMD, "cmd reads zero", 32'h0);
		rd(8'h1C, "unmapped", 32'h0);
		wr(link_pdu_pkg::OFS_CTRL, {16'h0, ME, 8'h00});
		rd(link_pdu_pkg::OFS_CTRL, "ctrl", {16'h0, ME, 8'h00});
		// Poll 0 test with default hold: timing and echo
		i_peer_station.send(link_pdu_pkg::PDU_TEST_CMD, 0, link_pdu_pkg::DST_INDIV, 8'h05, 0, 0,
			link_pdu_pkg::SUP_READY, 3, 32'hA1B2C300);
		lat = 0;
		#1;
		while (!tx_hdr_valid && lat < 100) begin
			@(posedge clk);
			#1;
			lat++;
		end
		chk("answer latency", 2 + link_pdu_pkg::HOLD_DEFAULT_CYC, lat);
		wait_frame();
		chk("test hdr", hd(link_pdu_pkg::PDU_TEST_RSP, 0, 8'h05, 0), got_hdr);
		chk("echo", 32'h00A1B2C3, got_data);
		// Poll 1 test: final 1, no data
		wr(link_pdu_pkg::OFS_HOLD, 32'h0);
		i_peer_station.send(link_pdu_pkg::PDU_TEST_CMD, 1, link_pdu_pkg::DST_INDIV, 8'h05, 0, 0,
			link_pdu_pkg::SUP_READY, 2, 32'h11220000);
		wait_frame();
		chk("poll test hdr", hd(link_pdu_pkg::PDU_TEST_RSP, 1, 8'h05, 0), got_hdr);
		chk("poll test len", 0, got_bytes);
		// Group poll 0 test against a stalling peer
		stall <= 1'b1;
		i_peer_station.send(link_pdu_pkg::PDU_TEST_CMD, 0, link_pdu_pkg::DST_GROUP, 8'h07, 0, 0,
			link_pdu_pkg::SUP_READY, 2, 32'h5A3C0000);
		wait_frame();
		stall <= 1'b0;
		chk("group test hdr", hd(link_pdu_pkg::PDU_TEST_RSP, 0, 8'h07, 0), got_hdr);
		chk("group echo", 32'h5A3C, got_data);
		// Busy station answers a polled UI; idle station does not
		wr(link_pdu_pkg::OFS_CTRL, {16'h0, ME, 8'h01});
		i_peer_station.send(link_pdu_pkg::PDU_UI_CMD, 1, link_pdu_pkg::DST_INDIV, 8'h09, 0, 0,
			link_pdu_pkg::SUP_READY, 1, 32'h77000000);
		wait_frame();
		chk("busy hdr", hd(link_pdu_pkg::PDU_URNR_RSP, 1, 8'h09, 0), got_hdr);
		wr(link_pdu_pkg::OFS_CTRL, {16'h0, ME, 8'h00});
		i_peer_station.send(link_pdu_pkg::PDU_UI_CMD, 1, link_pdu_pkg::DST_INDIV, 8'h09, 0, 0,
			link_pdu_pkg::SUP_READY, 1, 32'h77000000);
		repeat (30) @(posedge clk);
		chk("idle no answer", n, got_frames);
		// Received numbered frames: in order, out of order, group
		for (int i = 0; i < 4; i++)
			i_peer_station.send(link_pdu_pkg::PDU_I, 0, i == 3 ? link_pdu_pkg::DST_GROUP : link_pdu_pkg::DST_INDIV,
				8'h05, i == 2 ? 7'h05 : 7'(i), 0, link_pdu_pkg::SUP_READY, 1, 32'h33000000);
		rd(link_pdu_pkg::OFS_SEQ, "rx seq", 32'h00000200);
		rd(link_pdu_pkg::OFS_STATUS, "seq error", 32'h8);
		wr(link_pdu_pkg::OFS_STATUS, 32'h1C);
		// Software numbered, supervisory and group sends
		wr(link_pdu_pkg::OFS_BUF, 32'h5A);
		wr(link_pdu_pkg::OFS_CMD, 32'h00010901);
		wait_frame();
		chk("i hdr", hd(link_pdu_pkg::PDU_I, 0, 8'h09, {7'h0, 7'h2}), got_hdr);
		chk("i data", 32'h5A, got_data);
		wr(link_pdu_pkg::OFS_CMD, 32'h00000902);
		wait_frame();
		chk("s hdr", hd(link_pdu_pkg::PDU_S, 0, 8'h09, {7'h0, 7'h2}), got_hdr);
		chk("s len", 0, got_bytes);
		wr(link_pdu_pkg::OFS_CMD, 32'h00010905);
		wait_frame();
		chk("group seq", 0, got_hdr[13:0]);
		rd(link_pdu_pkg::OFS_SEQ, "tx seq", 32'h00000201);
		// Received supervisory frames: ready acks, selective reject without poll does not
		i_peer_station.send(link_pdu_pkg::PDU_S, 0, link_pdu_pkg::DST_INDIV, 8'h05, 0, 1,
			link_pdu_pkg::SUP_READY, 0, 32'h0);
		rd(link_pdu_pkg::OFS_SEQ, "s ack", 32'h00010201);
		i_peer_station.send(link_pdu_pkg::PDU_S, 0, link_pdu_pkg::DST_INDIV, 8'h05, 0, 0,
			link_pdu_pkg::SUP_SEL_REJECT, 0, 32'h0);
		rd(link_pdu_pkg::OFS_SEQ, "srej ack", 32'h00010201);
		wr(link_pdu_pkg::OFS_CMD, 32'h00000901);
		rd(link_pdu_pkg::OFS_STATUS, "empty i refused", 32'h10);
		summarize();
	end
endmodule : link_pdu_responder_tb
`default_nettype wire
